// ===== pkg/adcsp_pkg.sv
package adcsp_pkg;
    localparam int CTRL_BITS        = 8;
    localparam int RESULT_BITS      = 16;
    localparam int BIT_START        = 7;
    localparam int BIT_CODING       = 6;
    localparam int BIT_CLKSEL       = 5;
    localparam int BIT_MODE_HI      = 4;
    localparam int BIT_MODE_LO      = 3;
    localparam int BIT_USER2        = 2;
    localparam int BIT_USER1        = 1;
    localparam int BIT_USER0        = 0;
    localparam logic [1:0] MODE_SHORT = 2'h0;
    localparam logic [1:0] MODE_CAL   = 2'h1;
    localparam logic [1:0] MODE_PWDN  = 2'h2;
    localparam logic [1:0] MODE_LONG  = 2'h3;
    localparam logic [5:0] CLKS_SHORT = 6'h18;
    localparam logic [5:0] CLKS_LONG  = 6'h20;
    localparam logic [5:0] ACQ_SHORT  = 6'h05;
    localparam logic [5:0] ACQ_LONG   = 6'h0D;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int INT_CLK_DIV        = 2;
    localparam int FIFO_DEPTH         = 16;
endpackage

// ===== logic/adcsp_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// Result buffer between the converter and the serial shifter.
module adcsp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             clkEn,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW:0]      count;
    logic             doWr;
    logic             doRd;

    assign inReady  = (count != DEPTH[AW:0]);
    assign outValid = (count != '0);
    assign outData  = mem[rdPtr];
    assign doWr     = clkEn && inValid && inReady;
    assign doRd     = clkEn && outValid && outReady;

    always_ff @(posedge clk) begin
        if (doWr) begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (doWr) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (doRd) begin
                rdPtr <= rdPtr + 1'b1;
            end
            if (doWr && !doRd) begin
                count <= count + 1'b1;
            end else if (doRd && !doWr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // adcsp_fifo
`default_nettype wire

// ===== logic/adcsp_port.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Internal clock: strobe low during conversion.
// - External clock: strobe high one period pre-MSB.
// - External clock, deselected: strobe high impedance.
// - Result MSB first, binary or twos complement.
// - Serial output shows the MSB when a result is loaded, later bits on falling serial clock.
// - Serial input captured on rising serial clock.
// - Deselected means serial output high impedance.
// - External mode paced wholly by serial clock.
// - Acquisition lasts 5 or 13 cycles.
// - Shutdown input low blocks all conversions.
// - Reset restores power-on default configuration.
// - First one bit starts control byte.
// - Mode bits pick short, calibrate, powerdown, long.
// - Bit 5 picks internal or serial clock.
// - Bit 6 picks unipolar or bipolar coding.
module adcsp_port
    import adcsp_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire logic                   clkEn,
    input  wire logic                   chipSelect_n,
    input  wire logic                   serialClock,
    input  wire logic                   serialIn,
    input  wire logic                   shutdown_n,
    input  wire logic [RESULT_BITS-1:0] sampleValue,
    output logic                        serialOut,
    output logic                        serialOutEn,
    output logic                        conversion_strobe,
    output logic                        conversionStrobeEn,
    output logic                        user_out_0,
    output logic                        user_out_1,
    output logic                        user_out_2,
    output logic                        input_coding_select,
    output logic                        conv_clock_select,
    output logic                        op_mode_hi,
    output logic                        op_mode_lo,
    output logic                        calibrating
);
    typedef enum logic [1:0] {
        ADCSP_IDLE = 2'b00,
        ADCSP_CMD  = 2'b01,
        ADCSP_CONV = 2'b10,
        ADCSP_DONE = 2'b11
    } adcsp_state_t;

    logic [2:0] csSync;
    logic [2:0] sckSync;
    logic [1:0] dinSync;
    logic [1:0] shdnSync;
    logic       csActive;
    logic       sckRise;
    logic       sckFall;
    logic       din;
    logic       shdnLow;
    logic       csFall;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            csSync   <= 3'h7;
            sckSync  <= 3'h0;
            dinSync  <= 2'h0;
            shdnSync <= 2'h3;
        end else if (clkEn) begin
            csSync   <= {csSync[1:0], chipSelect_n};
            sckSync  <= {sckSync[1:0], serialClock};
            dinSync  <= {dinSync[0], serialIn};
            shdnSync <= {shdnSync[0], shutdown_n};
        end
    end

    assign csActive = !csSync[1];
    assign csFall   = csSync[2] && !csSync[1];
    assign sckRise  = clkEn && csActive && sckSync[1] && !sckSync[2];
    assign sckFall  = clkEn && csActive && !sckSync[1] && sckSync[2];
    assign din      = dinSync[1];
    assign shdnLow  = !shdnSync[1];

    logic [CTRL_BITS-1:0] ctrl;
    logic [CTRL_BITS-1:0] shiftIn;
    logic                 gotStart;
    logic [2:0]           inCount;
    logic                 byteDone;
    logic [1:0]           mode;
    logic                 intClk;
    adcsp_state_t         state;
    logic [5:0]           cycle;
    logic [5:0]           cycTotal;
    logic [5:0]           acqLen;
    logic                 tick;
    logic [INT_CLK_DIV-1:0] divCount;
    logic [RESULT_BITS-1:0] result;
    logic                 fifoInReady;
    logic                 fifoOutValid;
    logic                 fifoPop;
    logic [RESULT_BITS-1:0] fifoOutData;
    logic [RESULT_BITS-1:0] outShift;
    logic [4:0]           outCount;

    // A control byte is the start bit plus the seven bits that follow it.
    always_ff @(posedge clk) begin
        if (!reset_n || (clkEn && csFall)) begin
            gotStart <= 1'b0;
            inCount  <= 3'h0;
            shiftIn  <= '0;
        end else if (sckRise && state != ADCSP_CONV) begin
            if (!gotStart) begin
                gotStart <= din;
                shiftIn  <= {7'h00, din};
                inCount  <= 3'h0;
            end else begin
                shiftIn <= {shiftIn[CTRL_BITS-2:0], din};
                inCount <= inCount + 3'h1;
                if (inCount == 3'h6) begin
                    gotStart <= 1'b0;
                end
            end
        end
    end

    assign byteDone = sckRise && state != ADCSP_CONV && gotStart && inCount == 3'h6;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl <= CTRL_RESET;
        end else if (byteDone) begin
            ctrl <= {shiftIn[CTRL_BITS-2:0], din};
        end
    end

    assign mode                = {ctrl[BIT_MODE_HI], ctrl[BIT_MODE_LO]};
    assign intClk              = ctrl[BIT_CLKSEL];
    assign input_coding_select = ctrl[BIT_CODING];
    assign conv_clock_select   = ctrl[BIT_CLKSEL];
    assign op_mode_hi          = ctrl[BIT_MODE_HI];
    assign op_mode_lo          = ctrl[BIT_MODE_LO];
    assign user_out_0          = ctrl[BIT_USER0];
    assign user_out_1          = ctrl[BIT_USER1];
    assign user_out_2          = ctrl[BIT_USER2];

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            divCount <= '0;
        end else if (clkEn) begin
            divCount <= divCount + 1'b1;
        end
    end

    // Internal mode runs off a divided system clock, external mode off falling serial edges.
    assign tick     = intClk ? (clkEn && divCount == '0) : sckFall;
    assign cycTotal = (mode == MODE_LONG) ? CLKS_LONG : CLKS_SHORT;
    assign acqLen   = (mode == MODE_LONG) ? ACQ_LONG : ACQ_SHORT;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state       <= ADCSP_IDLE;
            cycle       <= 6'h00;
            result      <= '0;
            calibrating <= 1'b0;
        end else if (clkEn) begin
            case (state)
                ADCSP_IDLE: begin
                    if (byteDone) begin
                        state <= ADCSP_CMD;
                    end
                end
                ADCSP_CMD: begin
                    cycle <= 6'h00;
                    if (shdnLow || mode == MODE_PWDN) begin
                        state <= ADCSP_IDLE;
                    end else if (fifoInReady) begin
                        calibrating <= (mode == MODE_CAL);
                        state       <= ADCSP_CONV;
                    end
                end
                ADCSP_CONV: begin
                    if (shdnLow) begin
                        state <= ADCSP_IDLE;
                    end else if (tick) begin
                        cycle <= cycle + 6'h01;
                        if (cycle == acqLen - 6'h01) begin
                            // Two's complement flips the MSB of the offset-binary sample.
                            result <= input_coding_select ? sampleValue
                                    : {~sampleValue[RESULT_BITS-1],
                                       sampleValue[RESULT_BITS-2:0]};
                        end
                        if (cycle == cycTotal - 6'h01) begin
                            state <= ADCSP_DONE;
                        end
                    end
                end
                ADCSP_DONE: begin
                    calibrating <= 1'b0;
                    state       <= ADCSP_IDLE;
                end
                default: begin
                    state <= ADCSP_IDLE;
                end
            endcase
        end
    end

    adcsp_fifo #(
        .WIDTH (RESULT_BITS),
        .DEPTH (FIFO_DEPTH)
    ) resultFifo (
        .clk      (clk),
        .reset_n  (reset_n),
        .clkEn    (clkEn),
        .inValid  (state == ADCSP_DONE && !calibrating),
        .inReady  (fifoInReady),
        .inData   (result),
        .outValid (fifoOutValid),
        .outReady (fifoPop),
        .outData  (fifoOutData)
    );

    // A buffered result is loaded for shifting only while no word is being sent.
    assign fifoPop = outCount == 5'h00 && fifoOutValid && state != ADCSP_CONV;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            outShift  <= '0;
            outCount  <= 5'h00;
            serialOut <= 1'b0;
        end else if (clkEn) begin
            if (fifoPop) begin
                outShift  <= {fifoOutData[RESULT_BITS-2:0], 1'b0};
                outCount  <= 5'h10;
                serialOut <= fifoOutData[RESULT_BITS-1];
            end else if (sckFall && outCount != 5'h00) begin
                serialOut <= outShift[RESULT_BITS-1];
                outShift  <= {outShift[RESULT_BITS-2:0], 1'b0};
                outCount  <= outCount - 5'h01;
            end
        end
    end

    assign serialOutEn = csActive;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            conversion_strobe <= 1'b1;
        end else if (clkEn) begin
            if (intClk) begin
                // A refused command passes through CMD without converting, so only CONV pulls it low.
                conversion_strobe <= state != ADCSP_CONV;
            end else begin
                conversion_strobe <= state == ADCSP_CONV && cycle == acqLen - 6'h01;
            end
        end
    end

    assign conversionStrobeEn = intClk || csActive;
endmodule // adcsp_port
`default_nettype wire

// ===== sim/adcsp_port_sva.sv
`timescale 1ns/1ps
`default_nettype none
module adcsp_port_sva (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic chipSelect_n,
    input wire logic serialClock,
    input wire logic shutdown_n,
    input wire logic serialOut,
    input wire logic serialOutEn,
    input wire logic conversion_strobe,
    input wire logic conversionStrobeEn,
    input wire logic user_out_0,
    input wire logic user_out_1,
    input wire logic user_out_2,
    input wire logic input_coding_select,
    input wire logic conv_clock_select,
    input wire logic op_mode_hi,
    input wire logic op_mode_lo
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic [7:0] lowCnt;
    wire  [6:0] ctrl = {input_coding_select, conv_clock_select, op_mode_hi, op_mode_lo,
                        user_out_2, user_out_1, user_out_0};
    always_ff @(posedge clk) begin
        if (!reset_n || conversion_strobe || !conv_clock_select) begin
            lowCnt <= 8'h00;
        end else if (clkEn && lowCnt != 8'hFF) begin
            lowCnt <= lowCnt + 8'h01;
        end
    end
    idle_dout_a: assert property (chipSelect_n [*4] |-> !serialOutEn)
        else $error("data output driven while deselected");
    strobe_float_a: assert property (
        chipSelect_n [*4] ##0 !conv_clock_select |-> !conversionStrobeEn)
        else $error("strobe driven while deselected");
    dout_fall_a: assert property (
        serialOutEn && $past(serialOutEn) && $changed(serialOut)
        |-> !serialClock && !$past(serialClock, 2))
        else $error("data output moved outside a falling edge");
    ext_pulse_a: assert property (
        $rose(conversion_strobe) && conversionStrobeEn && !conv_clock_select
        |-> conversion_strobe [*8] ##1 !conversion_strobe)
        else $error("external strobe pulse not one period");
    int_len_a: assert property (lowCnt <= 8'h88)
        else $error("internal conversion too long");
    shutdown_n_hold_a: assert property (
        !shutdown_n [*5] ##0 conv_clock_select && conversion_strobe |=> conversion_strobe)
        else $error("conversion during shutdown");
    pwdn_hold_a: assert property (
        op_mode_hi && !op_mode_lo && conv_clock_select && conversion_strobe
        |=> conversion_strobe)
        else $error("conversion in power-down");
    rst_default_a: assert property ($rose(reset_n) |-> ctrl == 7'h00)
        else $error("control not default after reset");
endmodule // adcsp_port_sva
bind adcsp_port adcsp_port_sva u_adcsp_port_sva (.clk, .reset_n, .clkEn, .chipSelect_n, .serialClock,
    .shutdown_n, .serialOut, .serialOutEn, .conversion_strobe, .conversionStrobeEn,
    .user_out_0, .user_out_1, .user_out_2, .input_coding_select, .conv_clock_select,
    .op_mode_hi, .op_mode_lo);
`default_nettype wire

// ===== sim/adcsp_host.sv
`timescale 1ns/1ps
`default_nettype none
module adcsp_host (
    input  wire logic clk,
    input  wire logic dataLine,
    output logic      chipSelect_n,
    output logic      serialClock,
    output logic      serialIn
);
    initial begin
        chipSelect_n = 1'b1;
        serialClock  = 1'b0;
        serialIn     = 1'b0;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One 800 ns serial period; the returned bit is taken late in the high half.
    task automatic bit_io(input logic d, output logic q);
        serialIn = d;
        cyc(4);
        serialClock = 1'b1;
        cyc(3);
        q = dataLine;
        cyc(1);
        serialClock = 1'b0;
    endtask
    task automatic send(input logic [7:0] b, input int lead);
        logic q;
        repeat (lead) bit_io(1'b0, q);
        for (int i = 7; i >= 0; i--) bit_io(b[i], q);
    endtask
    task automatic clocks(input int n);
        logic q;
        repeat (n) bit_io(1'b0, q);
    endtask
    task automatic read(output logic [15:0] r);
        for (int i = 15; i >= 0; i--) bit_io(1'b0, r[i]);
    endtask
    task automatic open_frame();
        chipSelect_n = 1'b0;
        cyc(4);
    endtask
    // The data line is released, so it no longer shows the last bit.
    task automatic close_frame();
        cyc(4);
        chipSelect_n = 1'b1;
        serialIn = ~serialIn;
        cyc(4);
    endtask
endmodule // adcsp_host
`default_nettype wire

// ===== sim/tb_adcsp_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_adcsp_port;
    import adcsp_pkg::*;
    logic clk, reset_n, clkEn, shutdown_n, chipSelect_n, serialClock, serialIn;
    logic [RESULT_BITS-1:0] sampleValue;
    logic serialOut, serialOutEn, conversion_strobe, conversionStrobeEn, calibrating;
    logic user_out_0, user_out_1, user_out_2, input_coding_select, conv_clock_select;
    logic op_mode_hi, op_mode_lo;
    logic [15:0] got;
    int err_total, checks_done, hiBase, lowBase;
    int hiCnt = 0;
    int lowCnt = 0;
    wire dataLine = serialOutEn ? serialOut : 1'bz;
    wire strobeLine = conversionStrobeEn ? conversion_strobe : 1'bz;
    wire [15:0] ctrl = {9'h000, input_coding_select, conv_clock_select, op_mode_hi,
                        op_mode_lo, user_out_2, user_out_1, user_out_0};
    adcsp_port u_adcsp_port (.clk, .reset_n, .clkEn, .chipSelect_n, .serialClock,
        .serialIn, .shutdown_n, .sampleValue, .serialOut, .serialOutEn, .conversion_strobe,
        .conversionStrobeEn, .user_out_0, .user_out_1, .user_out_2, .input_coding_select,
        .conv_clock_select, .op_mode_hi, .op_mode_lo, .calibrating);
    adcsp_host u_adcsp_host (.clk, .dataLine, .chipSelect_n, .serialClock, .serialIn);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        hiCnt <= hiCnt + int'(strobeLine === 1'b1);
        lowCnt <= lowCnt + int'(strobeLine === 1'b0);
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wait_strobe(input logic v);
        int i;
        for (i = 0; i < 400 && strobeLine !== v; i++) u_adcsp_host.cyc(1);
        if (i == 400) begin
            err_total++;
            stop_test();
        end
    endtask
    initial begin
        reset_n = 1'b0;
        shutdown_n = 1'b1;
        sampleValue = 16'hA5C3;
        {err_total, checks_done} = '0;
        clkEn = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        reset_n = 1'b1;
        u_adcsp_host.cyc(4);
        chk(ctrl, 16'h0000);
        chk({14'h0000, serialOutEn, conversionStrobeEn}, 16'h0000);
        u_adcsp_host.open_frame();
        u_adcsp_host.send(8'hC5, 2);
        u_adcsp_host.cyc(4);
        chk(ctrl, 16'h0045);
        hiBase = hiCnt;
        // The falling edge that closes the control byte is the first conversion clock.
        u_adcsp_host.clocks(23);
        chk(16'(hiCnt - hiBase), 16'h0008);
        u_adcsp_host.cyc(16);
        u_adcsp_host.read(got);
        chk(got, 16'hA5C3);
        u_adcsp_host.close_frame();
        chk({14'h0000, serialOutEn, conversionStrobeEn}, 16'h0000);
        sampleValue = 16'h1234;
        u_adcsp_host.open_frame();
        u_adcsp_host.send(8'hBA, 0);
        wait_strobe(1'b0);
        lowBase = lowCnt;
        wait_strobe(1'b1);
        chk(ctrl, 16'h003A);
        chk(16'(lowCnt - lowBase >= 112 && lowCnt - lowBase <= 136), 16'h0001);
        u_adcsp_host.read(got);
        chk(got, 16'h9234);
        u_adcsp_host.close_frame();
        // Shutdown pin low first, then software power-down.
        for (int k = 0; k < 2; k++) begin
            shutdown_n = 1'(k);
            u_adcsp_host.open_frame();
            u_adcsp_host.send(k ? 8'hB0 : 8'hA0, 1);
            lowBase = lowCnt;
            u_adcsp_host.cyc(200);
            chk(16'(lowCnt - lowBase), 16'h0000);
            u_adcsp_host.close_frame();
        end
        u_adcsp_host.open_frame();
        u_adcsp_host.send(8'hA8, 0);
        u_adcsp_host.cyc(2);
        chk({15'h0000, calibrating}, 16'h0001);
        // A low clock enable must freeze the calibration run where it stands.
        clkEn = 1'b0;
        u_adcsp_host.cyc(150);
        chk({15'h0000, calibrating}, 16'h0001);
        clkEn = 1'b1;
        u_adcsp_host.cyc(150);
        chk({15'h0000, calibrating}, 16'h0000);
        u_adcsp_host.close_frame();
        reset_n = 1'b0;
        u_adcsp_host.cyc(2);
        reset_n = 1'b1;
        u_adcsp_host.cyc(3);
        chk(ctrl, 16'h0000);
        stop_test();
    end
endmodule // tb_adcsp_port
`default_nettype wire
